/* hw/page_prot_pkg.sv */
package page_prot_pkg;
   localparam int ENTRIES = 16;
   localparam int ADDR_W = 32;
   localparam int WAYS = 4;
   // register offsets (word addresses on the plain port)
   localparam logic [7:0] OFF_IMEM_CTRL = 8'h00;
   localparam logic [7:0] OFF_DMEM_CTRL = 8'h01;
   localparam logic [7:0] OFF_I_STATUS = 8'h02;
   localparam logic [7:0] OFF_D_STATUS = 8'h03;
   localparam logic [7:0] OFF_I_FADDR = 8'h04;
   localparam logic [7:0] OFF_D_FADDR = 8'h05;
   localparam logic [7:0] OFF_SEQUENCER_STATUS_REG = 8'h06;
   localparam logic [7:0] OFF_I_BASE = 8'h40;
   localparam logic [7:0] OFF_I_ATTR = 8'h50;
   localparam logic [7:0] OFF_D_BASE = 8'h60;
   localparam logic [7:0] OFF_D_ATTR = 8'h70;
   // instr control fields
   localparam int IC_ENABLE_BIT = 0;
   localparam int IC_CACHE_BIT = 1;
   localparam int IC_LRUCLR_BIT = 2;
   localparam int IC_LOCK_LSB = 3;
   // data control fields
   localparam int DC_ENABLE_BIT = 0;
   localparam int DC_CACHE_BIT = 1;
   // descriptor attribute fields
   localparam int AT_VALID = 0;
   localparam int AT_LOCK = 1;
   localparam int AT_USER_RD = 2;
   localparam int AT_USER_WR = 3;
   localparam int AT_SUPV_WR = 4;
   localparam int AT_SIZE_LSB = 5;
   // status fields
   localparam int ST_HIT_LSB = 0;
   localparam int ST_ILLADDR = 16;
   localparam int ST_MODE = 17;
   localparam int ST_GEN = 18;
   localparam int ST_RW = 19;
   // cause codes
   localparam logic [5:0] CAUSE_D_PROT = 6'h23;
   localparam logic [5:0] CAUSE_D_ALIGN = 6'h24;
   localparam logic [5:0] CAUSE_D_MISS = 6'h26;
   localparam logic [5:0] CAUSE_D_MULTI = 6'h27;
   localparam logic [5:0] CAUSE_I_PROT = 6'h2B;
   localparam logic [5:0] CAUSE_I_MISS = 6'h2C;
   localparam logic [5:0] CAUSE_I_MULTI = 6'h2D;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // instr cache window: upper 16K-byte bank
   localparam logic [31:0] CACHE_BANK_BASE = 32'hFFA1_0000;
   localparam logic [31:0] CACHE_BANK_SIZE = 32'h0000_4000;

   typedef enum logic [1:0] {PG_1K = 2'b00, PG_4K = 2'b01, PG_1M = 2'b10, PG_4M = 2'b11} page_size_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic user;
      logic write;
      logic [1:0] size_log2;
   } access_t;

   typedef struct packed {
      logic hit;
      logic multi;
      logic prot;
      logic [ENTRIES-1:0] hits;
   } check_t;
endpackage

/* hw/page_match.sv */
`timescale 1ns/10ps
module page_match
   import page_prot_pkg::*;
#(
   parameter int N = ENTRIES,
   parameter bit DATA_SIDE = 1'b1
)
(
   input wire access_t acc,
   input wire logic [N-1:0][31:0] base,
   input wire logic [N-1:0][31:0] attr,
   output check_t res
);
   logic [N-1:0] hit_vec;
   logic [N-1:0] deny_vec;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_ent
         logic [31:0] mask;
         logic [31:0] rel;
         always_comb
         begin
            unique case (page_size_t'(attr[g][AT_SIZE_LSB +: 2]))
               PG_1K: mask = 32'hFFFF_FC00;
               PG_4K: mask = 32'hFFFF_F000;
               PG_1M: mask = 32'hFFF0_0000;
               PG_4M: mask = 32'hFFC0_0000;
            endcase
            rel = acc.addr - base[g];
            // base aligned to own size; match if address in [base, base+size)
            hit_vec[g] = attr[g][AT_VALID] && ((rel & mask) == 32'h0000_0000) &&
                         ((base[g] & ~mask) == 32'h0000_0000);
            if (DATA_SIDE)
               deny_vec[g] = acc.write ? (acc.user ? !attr[g][AT_USER_WR] : !attr[g][AT_SUPV_WR])
                                       : (acc.user && !attr[g][AT_USER_RD]);
            else
               deny_vec[g] = acc.user && !attr[g][AT_USER_RD];
         end
      end
   endgenerate

   always_comb
   begin
      res.hits = hit_vec;
      res.hit = |hit_vec;
      res.multi = (hit_vec & (hit_vec - N'(1))) != '0;
      res.prot = |(hit_vec & deny_vec);
   end
endmodule

/* hw/page_protection_and_icache_lock.sv */
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
// How it works
// - data writes need per-mode write permit
// - user reads need user read permit
// - enabled checking, no match raises miss
// - separate instr/data fault status fields
// - data permission fault gives cause 0x23
// - misaligned data access gives cause 0x24
// - data miss 0x26, multi hit 0x27
// - fetch causes 0x2B, 0x2C, 0x2D
// - cause in six-bit sequencer status field
// - faulting address captured per side
// - miss priority fetch, generator 0, 1
// - 16 instr and 16 data entries
// - tag compare fetch stage 1, data 1
// - cache-configured memory refuses direct access
// - lru clear bit wipes lru priorities
// - four way locks protect valid lines
// - invalid lines in locked way replaceable
// - locked lines leave only by invalidate
// - cache enable maps upper bank, checking enable not needed
// - page sizes 1K,4K,1M,4M, size aligned
// - per-group enable bit for checking
module page_protection_and_icache_lock
   import page_prot_pkg::*;
#(
   parameter int N = ENTRIES,
   parameter int SETS = 32
)
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire access_t FETCH,
   input wire access_t DATA0,
   input wire access_t DATA1,
   input wire logic DMA_VALID,
   input wire logic [31:0] DMA_ADDR,
   input wire logic ICACHE_MISS,
   input wire logic [$clog2(SETS)-1:0] ICACHE_SET,
   input wire logic [WAYS-1:0] ICACHE_LINE_VALID,
   input wire logic [WAYS-1:0] ICACHE_LRU_ORDER,
   input wire logic LINE_INVALIDATE,
   output logic FETCH_GRANT,
   output logic DATA0_GRANT,
   output logic DATA1_GRANT,
   output logic DMA_REFUSED,
   output logic EXC_VALID,
   output logic [5:0] EXC_CAUSE,
   output logic [WAYS-1:0] VICTIM_WAY,
   output logic VICTIM_VALID,
   output logic [SETS-1:0] LRU_PRIO
);
   // ----------------------------------------
   // descriptor tables and control
   // ----------------------------------------
   logic [N-1:0][31:0] i_base_reg, i_base_next, i_attr_reg, i_attr_next;
   logic [N-1:0][31:0] d_base_reg, d_base_next, d_attr_reg, d_attr_next;
   logic [31:0] imem_reg, imem_next, dmem_reg, dmem_next;

   always_comb
   begin
      i_base_next = i_base_reg;
      i_attr_next = i_attr_reg;
      d_base_next = d_base_reg;
      d_attr_next = d_attr_reg;
      imem_next = imem_reg;
      dmem_next = dmem_reg;
      imem_next[IC_LRUCLR_BIT] = 1'b0;
      if (WR)
      begin
         if (ADDR == OFF_IMEM_CTRL)
            imem_next = WDATA;
         if (ADDR == OFF_DMEM_CTRL)
            dmem_next = WDATA;
         // tables take writes only while their group is disabled
         if (ADDR[7:4] == OFF_I_BASE[7:4] && !imem_reg[IC_ENABLE_BIT])
            i_base_next[ADDR[3:0]] = WDATA;
         if (ADDR[7:4] == OFF_I_ATTR[7:4] && !imem_reg[IC_ENABLE_BIT])
            i_attr_next[ADDR[3:0]] = WDATA;
         if (ADDR[7:4] == OFF_D_BASE[7:4] && !dmem_reg[DC_ENABLE_BIT])
            d_base_next[ADDR[3:0]] = WDATA;
         if (ADDR[7:4] == OFF_D_ATTR[7:4] && !dmem_reg[DC_ENABLE_BIT])
            d_attr_next[ADDR[3:0]] = WDATA;
      end
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         i_base_reg <= '0;
         i_attr_reg <= '0;
         d_base_reg <= '0;
         d_attr_reg <= '0;
         imem_reg <= RESET_WORD;
         dmem_reg <= RESET_WORD;
      end
      else
      begin
         i_base_reg <= i_base_next;
         i_attr_reg <= i_attr_next;
         d_base_reg <= d_base_next;
         d_attr_reg <= d_attr_next;
         imem_reg <= imem_next;
         dmem_reg <= dmem_next;
      end
   end

   // ----------------------------------------
   // address checks
   // ----------------------------------------
   check_t i_chk, d0_chk, d1_chk;

   page_match #(.N(N), .DATA_SIDE(1'b0)) u_imatch (.acc(FETCH), .base(i_base_reg), .attr(i_attr_reg), .res(i_chk));
   page_match #(.N(N), .DATA_SIDE(1'b1)) u_d0match (.acc(DATA0), .base(d_base_reg), .attr(d_attr_reg), .res(d0_chk));
   page_match #(.N(N), .DATA_SIDE(1'b1)) u_d1match (.acc(DATA1), .base(d_base_reg), .attr(d_attr_reg), .res(d1_chk));

   function automatic logic misaligned(input access_t a);
      logic [3:0] m;
      m = 4'((5'b00001 << a.size_log2) - 5'b00001);
      return (a.addr[3:0] & m) != 4'h0;
   endfunction

   function automatic logic [5:0] data_cause(input access_t a, input check_t c, input logic en);
      logic [5:0] r;
      r = 6'h00;
      if (a.valid)
      begin
         if (misaligned(a))
            r = CAUSE_D_ALIGN;
         else if (en && c.multi)
            r = CAUSE_D_MULTI;
         else if (en && !c.hit)
            r = CAUSE_D_MISS;
         else if (en && c.prot)
            r = CAUSE_D_PROT;
      end
      return r;
   endfunction

   logic i_en, d_en;
   logic [5:0] i_cause, d0_cause, d1_cause;
   logic in_cache_i, dma_hits_cache, d0_bank, d1_bank;

   always_comb
   begin
      i_en = imem_reg[IC_ENABLE_BIT];
      d_en = dmem_reg[DC_ENABLE_BIT];
      i_cause = 6'h00;
      // fetch checked in fetch_stage_one as it issues on instr_address_bus
      if (FETCH.valid && i_en)
      begin
         if (i_chk.multi)
            i_cause = CAUSE_I_MULTI;
         else if (!i_chk.hit)
            i_cause = CAUSE_I_MISS;
         else if (i_chk.prot)
            i_cause = CAUSE_I_PROT;
      end
      // data checked in data_fetch_stage_one on both data buses
      d0_cause = data_cause(DATA0, d0_chk, d_en);
      d1_cause = data_cause(DATA1, d1_chk, d_en);
      // bank configured as cache refuses direct data and dma access
      in_cache_i = imem_reg[IC_CACHE_BIT] && (DMA_ADDR - CACHE_BANK_BASE) < CACHE_BANK_SIZE;
      dma_hits_cache = DMA_VALID && in_cache_i;
      d0_bank = imem_reg[IC_CACHE_BIT] && (DATA0.addr - CACHE_BANK_BASE) < CACHE_BANK_SIZE;
      d1_bank = imem_reg[IC_CACHE_BIT] && (DATA1.addr - CACHE_BANK_BASE) < CACHE_BANK_SIZE;
   end

   // ----------------------------------------
   // exception, status and fault address
   // ----------------------------------------
   logic [31:0] i_stat_reg, i_stat_next, d_stat_reg, d_stat_next;
   logic [31:0] i_fa_reg, i_fa_next, d_fa_reg, d_fa_next;
   logic [5:0] cause_reg, cause_next;
   logic exc_reg, exc_next;
   logic fg_reg, fg_next, d0g_reg, d0g_next, d1g_reg, d1g_next, dmar_reg, dmar_next;

   always_comb
   begin
      access_t a;
      check_t c;
      logic gen;
      gen = (d0_cause == 6'h00);
      a = gen ? DATA1 : DATA0;
      c = gen ? d1_chk : d0_chk;
      i_stat_next = i_stat_reg;
      d_stat_next = d_stat_reg;
      i_fa_next = i_fa_reg;
      d_fa_next = d_fa_reg;
      cause_next = cause_reg;
      exc_next = 1'b0;
      // abort: only accesses without a cause are granted
      fg_next = FETCH.valid && i_cause == 6'h00;
      d0g_next = DATA0.valid && !d0_bank && d0_cause == 6'h00 && i_cause == 6'h00;
      d1g_next = DATA1.valid && !d1_bank && d1_cause == 6'h00 && d0_cause == 6'h00 && i_cause == 6'h00;
      dmar_next = dma_hits_cache;
      // priority fetch, then generator zero, then generator one
      if (i_cause != 6'h00)
      begin
         exc_next = 1'b1;
         cause_next = i_cause;
         i_stat_next = '0;
         i_stat_next[ST_HIT_LSB +: N] = i_chk.hits;
         i_stat_next[ST_ILLADDR] = !i_chk.hit;
         i_stat_next[ST_MODE] = FETCH.user;
         i_fa_next = FETCH.addr;
      end
      else if (d0_cause != 6'h00 || d1_cause != 6'h00)
      begin
         exc_next = 1'b1;
         cause_next = gen ? d1_cause : d0_cause;
         d_stat_next = '0;
         d_stat_next[ST_HIT_LSB +: N] = c.hits;
         d_stat_next[ST_ILLADDR] = !c.hit;
         d_stat_next[ST_MODE] = a.user;
         d_stat_next[ST_GEN] = gen;
         d_stat_next[ST_RW] = a.write;
         d_fa_next = a.addr;
      end
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         i_stat_reg <= RESET_WORD;
         d_stat_reg <= RESET_WORD;
         i_fa_reg <= RESET_WORD;
         d_fa_reg <= RESET_WORD;
         cause_reg <= 6'h00;
         exc_reg <= 1'b0;
         fg_reg <= 1'b0;
         d0g_reg <= 1'b0;
         d1g_reg <= 1'b0;
         dmar_reg <= 1'b0;
      end
      else
      begin
         i_stat_reg <= i_stat_next;
         d_stat_reg <= d_stat_next;
         i_fa_reg <= i_fa_next;
         d_fa_reg <= d_fa_next;
         cause_reg <= cause_next;
         exc_reg <= exc_next;
         fg_reg <= fg_next;
         d0g_reg <= d0g_next;
         d1g_reg <= d1g_next;
         dmar_reg <= dmar_next;
      end
   end

   // ----------------------------------------
   // instr cache replacement and lru
   // ----------------------------------------
   logic [SETS-1:0] lru_reg, lru_next;
   logic [WAYS-1:0] vic_reg, vic_next;
   logic vv_reg, vv_next;

   always_comb
   begin
      logic [WAYS-1:0] lock;
      logic [WAYS-1:0] ok;
      lock = imem_reg[IC_LOCK_LSB +: WAYS];
      lru_next = lru_reg;
      vic_next = '0;
      vv_next = 1'b0;
      // locked way eligible only when its line is invalid
      ok = ~ICACHE_LINE_VALID | ~lock;
      if (ICACHE_MISS && imem_reg[IC_CACHE_BIT])
      begin
         for (int w = WAYS - 1; w >= 0; w--)
            if (ok[w] && (!ICACHE_LINE_VALID[w] || ICACHE_LRU_ORDER[w] || vic_next == '0))
            begin
               if (!(vic_next != '0 && !ICACHE_LINE_VALID[w] == 1'b0 && !ICACHE_LRU_ORDER[w]))
                  vic_next = WAYS'(1) << w;
            end
         vv_next = vic_next != '0;
         if (vv_next)
            lru_next[ICACHE_SET] = 1'b1;
      end
      if (LINE_INVALIDATE)
         lru_next[ICACHE_SET] = 1'b0;
      if (imem_reg[IC_LRUCLR_BIT])
         lru_next = '0;
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         lru_reg <= '0;
         vic_reg <= '0;
         vv_reg <= 1'b0;
      end
      else
      begin
         lru_reg <= lru_next;
         vic_reg <= vic_next;
         vv_reg <= vv_next;
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   logic [31:0] rdata_reg, rdata_next;

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (RD)
      begin
         unique case (ADDR[7:4])
            OFF_I_BASE[7:4]: rdata_next = i_base_reg[ADDR[3:0]];
            OFF_I_ATTR[7:4]: rdata_next = i_attr_reg[ADDR[3:0]];
            OFF_D_BASE[7:4]: rdata_next = d_base_reg[ADDR[3:0]];
            OFF_D_ATTR[7:4]: rdata_next = d_attr_reg[ADDR[3:0]];
            default:
            begin
               if (ADDR == OFF_IMEM_CTRL)
                  rdata_next = imem_reg;
               else if (ADDR == OFF_DMEM_CTRL)
                  rdata_next = dmem_reg;
               else if (ADDR == OFF_I_STATUS)
                  rdata_next = i_stat_reg;
               else if (ADDR == OFF_D_STATUS)
                  rdata_next = d_stat_reg;
               else if (ADDR == OFF_I_FADDR)
                  rdata_next = i_fa_reg;
               else if (ADDR == OFF_D_FADDR)
                  rdata_next = d_fa_reg;
               else if (ADDR == OFF_SEQUENCER_STATUS_REG)
                  rdata_next = {26'h0, cause_reg};
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         rdata_reg <= 32'h0000_0000;
      else
         rdata_reg <= rdata_next;
   end

   assign RDATA = rdata_reg;
   assign FETCH_GRANT = fg_reg;
   assign DATA0_GRANT = d0g_reg;
   assign DATA1_GRANT = d1g_reg;
   assign DMA_REFUSED = dmar_reg;
   assign EXC_VALID = exc_reg;
   assign EXC_CAUSE = cause_reg;
   assign VICTIM_WAY = vic_reg;
   assign VICTIM_VALID = vv_reg;
   assign LRU_PRIO = lru_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   fetch_miss_a: assert property (@(posedge CLOCK) disable iff (RST)
      (FETCH.valid && i_en && !i_chk.hit && !i_chk.multi) |=> (EXC_VALID && EXC_CAUSE == 6'h2C && !FETCH_GRANT))
      else $error("fetch miss not raised");
   fetch_first_a: assert property (@(posedge CLOCK) disable iff (RST)
      (FETCH.valid && i_en && !i_chk.hit && DATA0.valid && d0_cause != 6'h00) |=> (EXC_CAUSE == 6'h2C))
      else $error("fetch miss lost priority");
   data_align_a: assert property (@(posedge CLOCK) disable iff (RST)
      (i_cause == 6'h00 && DATA0.valid && DATA0.size_log2 == 2'b10 && DATA0.addr[1:0] != 2'b00)
      |=> (EXC_CAUSE == 6'h24 && !DATA0_GRANT))
      else $error("misaligned access not raised");
   data_prot_a: assert property (@(posedge CLOCK) disable iff (RST)
      (i_cause == 6'h00 && d0_cause == 6'h00 && d1_cause == 6'h23) |=> (EXC_CAUSE == 6'h23 && d_stat_reg[ST_GEN]))
      else $error("protection cause wrong");
   data_fault_a: assert property (@(posedge CLOCK) disable iff (RST)
      (i_cause == 6'h00 && d0_cause == 6'h26) |=> (d_fa_reg == $past(DATA0.addr) && d_stat_reg[ST_ILLADDR]))
      else $error("fault address not captured");
   grant_abort_a: assert property (@(posedge CLOCK) disable iff (RST)
      (DATA1.valid && d1_cause != 6'h00) |=> (EXC_VALID && !DATA1_GRANT))
      else $error("faulting access granted");
   lock_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      VICTIM_VALID |-> ((VICTIM_WAY & $past(ICACHE_LINE_VALID) & $past(imem_reg[IC_LOCK_LSB +: WAYS])) == '0))
      else $error("locked valid way replaced");
   lru_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      (WR && ADDR == OFF_IMEM_CTRL && WDATA[IC_LRUCLR_BIT]) |=> ##1 (LRU_PRIO == '0))
      else $error("lru priorities not cleared");
   dma_refuse_a: assert property (@(posedge CLOCK) disable iff (RST)
      (DMA_VALID && imem_reg[IC_CACHE_BIT] && DMA_ADDR[31:14] == CACHE_BANK_BASE[31:14]) |=> DMA_REFUSED)
      else $error("cache bank access not refused");
endmodule

/* tb/core_access_model.sv */
`timescale 1ns/10ps
module core_access_model
   import page_prot_pkg::*;
(
   input wire logic clock,
   output access_t fetch,
   output access_t data0,
   output access_t data1
);
   // --------------------------------
   // idle buses show a changed address
   // --------------------------------
   function automatic access_t idle(input access_t x);
      return '{1'b0, ~x.addr, 1'b0, 1'b0, 2'b00};
   endfunction

   initial
   begin
      fetch = '0;
      data0 = '0;
      data1 = '0;
   end

   // --------------------------------
   // one access per bus, held one cycle
   // --------------------------------
   task automatic issue(input access_t f, input access_t d0, input access_t d1);
      @(posedge clock);
      fetch <= f;
      data0 <= d0;
      data1 <= d1;
      @(posedge clock);
      fetch <= idle(f);
      data0 <= idle(d0);
      data1 <= idle(d1);
   endtask
endmodule

/* tb/test_page_protection_and_icache_lock.sv */
`timescale 1ns/10ps
module test_page_protection_and_icache_lock
   import page_prot_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [31:0] rdata;
   access_t fetch;
   access_t data0;
   access_t data1;
   logic dma_valid = 1'b0;
   logic [31:0] dma_addr = '0;
   logic miss = 1'b0;
   logic [4:0] set_idx = '0;
   logic [3:0] line_valid = '0;
   logic [3:0] lru_order = '0;
   logic invalidate = 1'b0;
   logic fetch_grant, data0_grant, data1_grant, dma_refused, exc_valid, victim_valid;
   logic [5:0] exc_cause;
   logic [3:0] victim_way;
   logic [31:0] lru_prio;
   int n_mismatch = 0;
   int comparisons = 0;

   always #2 clock = ~clock;

   page_protection_and_icache_lock i_page_protection_and_icache_lock (.CLOCK(clock), .RST(rst),
      .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .FETCH(fetch), .DATA0(data0),
      .DATA1(data1), .DMA_VALID(dma_valid), .DMA_ADDR(dma_addr), .ICACHE_MISS(miss), .ICACHE_SET(set_idx),
      .ICACHE_LINE_VALID(line_valid), .ICACHE_LRU_ORDER(lru_order), .LINE_INVALIDATE(invalidate),
      .FETCH_GRANT(fetch_grant), .DATA0_GRANT(data0_grant), .DATA1_GRANT(data1_grant),
      .DMA_REFUSED(dma_refused), .EXC_VALID(exc_valid), .EXC_CAUSE(exc_cause), .VICTIM_WAY(victim_way),
      .VICTIM_VALID(victim_valid), .LRU_PRIO(lru_prio));

   core_access_model i_core_access_model (.clock(clock), .fetch(fetch), .data0(data0), .data1(data1));

   // ------------------
   // compare and finish
   // ------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------
   // register port
   // ------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clock);
      wr_s <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clock);
      rd_s <= 1'b0;
      #1;
      check(rdata & mask, exp);
   endtask

   task automatic desc(input logic [7:0] b_off, input logic [7:0] a_off, input logic [7:0] i,
                       input logic [31:0] base, input logic [31:0] attr);
      wr(b_off + i, base);
      wr(a_off + i, attr);
   endtask

   // ------------------
   // core accesses
   // ------------------
   function automatic access_t ac(input logic [31:0] a, input logic u, input logic w, input logic [1:0] s);
      return '{1'b1, a, u, w, s};
   endfunction

   task automatic acc(input access_t f, input access_t d0, input access_t d1,
                      input logic e, input logic [5:0] c, input logic [2:0] g);
      i_core_access_model.issue(f, d0, d1);
      #1;
      check(exc_valid, e);
      if (e)
         check(exc_cause, c);
      check({fetch_grant, data0_grant, data1_grant}, g);
   endtask

   task automatic pulse_probe(input logic d, input logic [31:0] da, input logic m, input logic [3:0] lv);
      @(posedge clock);
      dma_valid <= d;
      dma_addr <= da;
      miss <= m;
      line_valid <= lv;
      lru_order <= 4'h1;
      @(posedge clock);
      dma_valid <= 1'b0;
      miss <= 1'b0;
      #1;
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      conclude();
   end

   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rdchk(8'h30, 32'hFFFF_FFFF, 32'h0);
      acc('0, ac(32'h5000_0000, 0, 0, 2), '0, 0, 6'h0, 3'b010);
      desc(OFF_D_BASE, OFF_D_ATTR, 0, 32'h1000_0000, 32'h15);
      desc(OFF_D_BASE, OFF_D_ATTR, 1, 32'h2000_0000, 32'h3F);
      desc(OFF_D_BASE, OFF_D_ATTR, 2, 32'h4000_0000, 32'h11);
      desc(OFF_D_BASE, OFF_D_ATTR, 15, 32'h2000_0400, 32'h15);
      desc(OFF_D_BASE, OFF_D_ATTR, 3, CACHE_BANK_BASE, 32'h15);
      desc(OFF_I_BASE, OFF_I_ATTR, 0, 32'h3000_0000, 32'h01);
      desc(OFF_I_BASE, OFF_I_ATTR, 1, 32'h3100_0000, 32'h05);
      desc(OFF_I_BASE, OFF_I_ATTR, 2, 32'h3100_0000, 32'h05);
      wr(OFF_DMEM_CTRL, 32'h1);
      wr(OFF_IMEM_CTRL, 32'h1);
      desc(OFF_D_BASE, OFF_D_ATTR, 5, 32'h7000_0000, 32'h15);
      rdchk(OFF_D_ATTR + 8'h05, 32'hFFFF_FFFF, 32'h0);
      rdchk(OFF_D_ATTR + 8'h01, 32'hFFFF_FFFF, 32'h3F);
      acc('0, ac(32'h1000_0010, 0, 0, 2), '0, 0, 6'h0, 3'b010);
      acc('0, ac(32'h1000_0010, 1, 1, 2), '0, 1, 6'h23, 3'b000);
      acc('0, ac(32'h1000_0010, 0, 1, 2), '0, 0, 6'h0, 3'b010);
      acc('0, '0, ac(32'h4000_0000, 1, 0, 2), 1, 6'h23, 3'b000);
      rdchk(OFF_D_STATUS, 32'h000E_0000, 32'h0006_0000);
      acc('0, ac(32'h1000_0002, 0, 0, 2), '0, 1, 6'h24, 3'b000);
      acc('0, ac(32'h2000_0400, 0, 0, 0), '0, 1, 6'h27, 3'b000);
      acc('0, ac(32'h2000_0000, 1, 1, 0), '0, 0, 6'h0, 3'b010);
      acc('0, ac(32'h5000_0000, 0, 0, 2), '0, 1, 6'h26, 3'b000);
      rdchk(OFF_D_FADDR, 32'hFFFF_FFFF, 32'h5000_0000);
      acc(ac(32'h3000_0000, 0, 0, 2), '0, '0, 0, 6'h0, 3'b100);
      acc(ac(32'h3000_0000, 1, 0, 2), '0, '0, 1, 6'h2B, 3'b000);
      rdchk(OFF_I_STATUS, 32'h0002_0000, 32'h0002_0000);
      acc(ac(32'h3100_0000, 0, 0, 2), '0, '0, 1, 6'h2D, 3'b000);
      acc(ac(32'h6000_0000, 0, 0, 2), ac(32'h5000_0100, 0, 0, 2), ac(32'h5000_0200, 0, 0, 2),
          1, 6'h2C, 3'b000);
      rdchk(OFF_I_FADDR, 32'hFFFF_FFFF, 32'h6000_0000);
      acc('0, ac(32'h5000_0300, 0, 0, 2), ac(32'h5000_0400, 0, 0, 2), 1, 6'h26, 3'b000);
      rdchk(OFF_D_FADDR, 32'hFFFF_FFFF, 32'h5000_0300);
      rdchk(OFF_SEQUENCER_STATUS_REG, 32'h0000_003F, 32'h26);
      wr(OFF_IMEM_CTRL, 32'h0B);
      acc('0, ac(CACHE_BANK_BASE, 0, 0, 2), '0, 0, 6'h0, 3'b000);
      pulse_probe(1, CACHE_BANK_BASE + 32'h10, 0, 4'h0);
      check(dma_refused, 1'b1);
      pulse_probe(1, 32'h1000_0000, 0, 4'h0);
      check(dma_refused, 1'b0);
      pulse_probe(0, 32'h0, 1, 4'hF);
      check(victim_valid, 1'b1);
      check(victim_way & 4'h1, 4'h0);
      pulse_probe(0, 32'h0, 1, 4'hE);
      check(victim_way, 4'h1);
      wr(OFF_IMEM_CTRL, 32'h0F);
      repeat (2) @(posedge clock);
      #1;
      check(lru_prio, 32'h0);
      conclude();
   end
endmodule
